// >>> thcs_pkg.sv
// Package of shared constants for the terminal host control signal block.
package thcs_pkg;
   localparam int          THCS_CLK_MHZ        = 100;
   localparam int          THCS_IRQ_PULSE_NS   = 500;
   localparam int          THCS_IRQ_PULSE_CYC  = (THCS_IRQ_PULSE_NS * THCS_CLK_MHZ) / 1000;
   localparam int          THCS_RST_STROBE_CYC = 2;
   localparam int          THCS_SELFTEST_CYC   = 64;
   localparam int          THCS_CFG2_LEVEL_BIT = 3;
   localparam int          THCS_CFG2_AUTOCLR   = 4;
   localparam int          THCS_CFG2_TAG_LO    = 7;
   localparam int          THCS_CFG2_TAG_HI    = 9;
   localparam int          THCS_START_IRQ_RST  = 2;
   // Controller register byte offsets on the AXI4-Lite slave.
   localparam logic [7:0]  THCS_OFF_CFG2       = 8'h00;
   localparam logic [7:0]  THCS_OFF_START      = 8'h04;
   localparam logic [7:0]  THCS_OFF_ISR1       = 8'h08;
   localparam logic [7:0]  THCS_OFF_ISR2       = 8'h0C;
   localparam logic [7:0]  THCS_OFF_IMR        = 8'h10;
   localparam logic [7:0]  THCS_OFF_EVENT      = 8'h14;
   localparam logic [7:0]  THCS_OFF_STATUS     = 8'h18;
   localparam logic [7:0]  THCS_OFF_TAG        = 8'h1C;
   localparam logic [7:0]  THCS_OFF_CTRL       = 8'h20;
   localparam logic [7:0]  THCS_OFF_HIRQ       = 8'h24;
   localparam logic [7:0]  THCS_OFF_HMASK      = 8'h28;
   localparam logic [15:0] THCS_CFG2_RESET     = 16'h0000;
   localparam logic [1:0]  THCS_RESP_OKAY      = 2'h0;
   localparam logic [1:0]  THCS_RESP_SLVERR    = 2'h2;
   typedef enum logic [1:0] {
      THCS_MODE_BC   = 2'b00,
      THCS_MODE_RT   = 2'b01,
      THCS_MODE_SMM  = 2'b10,
      THCS_MODE_WMON = 2'b11
   } thcs_mode_e;
   typedef enum logic [1:0] {
      THCS_ST_IDLE = 2'b00,
      THCS_ST_TEST = 2'b01,
      THCS_ST_RUN  = 2'b10
   } thcs_state_e;
endpackage

// >>> thcs_if.sv
// Interface joining the terminal and its controlling host.
`timescale 1ns/1ps
interface thcs_if;
   logic        master_clear_n;
   logic        selftest_after_reset_en;
   logic        tx_shutdown_chan_a;
   logic        tx_shutdown_chan_b;
   logic        tag_clk;
   logic        message_in_progress_n;
   logic        rt_reset_cmd_strobe_n;
   logic        irq_n;
   logic        reg_wr;
   logic        reg_rd;
   logic [7:0]  reg_addr;
   logic [15:0] reg_wdata;
   logic [15:0] reg_rdata;
   modport device (
      input  master_clear_n, selftest_after_reset_en, tx_shutdown_chan_a, tx_shutdown_chan_b, tag_clk,
      input  reg_wr, reg_rd, reg_addr, reg_wdata,
      output message_in_progress_n, rt_reset_cmd_strobe_n, irq_n, reg_rdata
   );
   modport host (
      output master_clear_n, selftest_after_reset_en, tx_shutdown_chan_a, tx_shutdown_chan_b, tag_clk,
      output reg_wr, reg_rd, reg_addr, reg_wdata,
      input  message_in_progress_n, rt_reset_cmd_strobe_n, irq_n, reg_rdata
   );
endinterface

// >>> thcs_device.sv
// Terminal end: message status, reset strobe, self-test, interrupt output and time tag.
//
// What this block does
// - Message-in-progress low while BC/RT/SMM handle messages.
// - Message-in-progress low whole time word monitor online.
// - Reset-terminal command in RT mode gives two-cycle low strobe.
// - Self-test runs after reset when enable high.
// - Enable low blocks power-up and user self-test.
// - Level-select zero: interrupt is 500 ns low pulse.
// - Level-select one: interrupt held low until cleared.
// - Writing interrupt-reset bit releases level interrupt.
// - Auto-clear: reading requesting status register clears interrupt.
// - Both status registers pending: both reads needed.
// - Host supplies clock at an allowed frequency.
// - Transmitter shutdown inputs low for normal operation.
// - Shutdown input high stops that channel's transmitter.
// - Master clear low resets the device.
// - Config bits 7-9 all set: external time-tag clock.
//
// Decided for this implementation: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
module thcs_device
   import thcs_pkg::*;
#(
   parameter int PULSE_CYC = THCS_IRQ_PULSE_CYC
) (
   input  wire logic        aclk,
   thcs_if.device           link,
   input  wire thcs_mode_e  mode,
   input  wire logic        monitor_online,
   input  wire logic        msg_active,
   input  wire logic        rt_reset_cmd_rx,
   input  wire logic [15:0] isr1_event,
   input  wire logic [15:0] isr2_event,
   output logic             tx_enable_a,
   output logic             tx_enable_b,
   output logic             selftest_busy,
   output logic [15:0]      time_tag
);
   import thcs_pkg::*;

   logic [15:0] cfg2_reg;
   logic [15:0] imr_reg;
   logic [15:0] isr1_reg;
   logic [15:0] isr2_reg;
   logic        level_reg;
   logic [15:0] pulse_cnt_reg;
   logic [1:0]  strobe_cnt_reg;
   logic [7:0]  test_cnt_reg;
   logic        tag_d1_reg;
   logic        tag_d2_reg;
   logic        tag_d3_reg;
   logic        inprog_reg;
   thcs_state_e state_reg;

   wire rst      = ~link.master_clear_n;
   wire wr_start = link.reg_wr && link.reg_addr == THCS_OFF_START;
   wire rd_isr1  = link.reg_rd && link.reg_addr == THCS_OFF_ISR1;
   wire rd_isr2  = link.reg_rd && link.reg_addr == THCS_OFF_ISR2;
   wire [15:0] new1 = isr1_event & imr_reg;
   wire [15:0] new2 = isr2_event & imr_reg;
   wire new_evt  = |new1 || |new2;
   wire autoclr  = cfg2_reg[THCS_CFG2_AUTOCLR];
   wire ext_tag  = &cfg2_reg[THCS_CFG2_TAG_HI:THCS_CFG2_TAG_LO];
   wire irq_clr  = wr_start && link.reg_wdata[THCS_START_IRQ_RST];
   wire isr_read = autoclr && (rd_isr1 || rd_isr2);
   wire pulse_on = pulse_cnt_reg != 16'h0000;
   wire stb_on   = strobe_cnt_reg != 2'h0;
   wire tag_rise = tag_d2_reg && !tag_d3_reg;

   always_ff @(posedge aclk) begin
      if (rst) begin
         cfg2_reg <= THCS_CFG2_RESET;
         imr_reg  <= 16'h0000;
      end else if (link.reg_wr) begin
         if (link.reg_addr == THCS_OFF_CFG2)
            cfg2_reg <= link.reg_wdata;
         if (link.reg_addr == THCS_OFF_IMR)
            imr_reg <= link.reg_wdata;
      end
   end

   // New events win over a clearing read in the same cycle.
   always_ff @(posedge aclk) begin
      if (rst) begin
         isr1_reg <= 16'h0000;
         isr2_reg <= 16'h0000;
      end else begin
         isr1_reg <= (rd_isr1 ? 16'h0000 : isr1_reg) | new1;
         isr2_reg <= (rd_isr2 ? 16'h0000 : isr2_reg) | new2;
      end
   end

   // Level stays low until the reset bit is written or, with auto-clear, every pending register has been read.
   always_ff @(posedge aclk) begin
      if (rst) begin
         level_reg <= 1'b0;
      end else if (new_evt && cfg2_reg[THCS_CFG2_LEVEL_BIT]) begin
         level_reg <= 1'b1;
      end else if (irq_clr) begin
         level_reg <= 1'b0;
      end else if (isr_read) begin
         // A clearing read may only lower the level, never raise one already released.
         level_reg <= level_reg && ((|isr1_reg && !rd_isr1) || (|isr2_reg && !rd_isr2));
      end
   end

   // A new event restarts the count, so events close together merge into one pulse.
   always_ff @(posedge aclk) begin
      if (rst) begin
         pulse_cnt_reg <= 16'h0000;
      end else if (new_evt && !cfg2_reg[THCS_CFG2_LEVEL_BIT]) begin
         pulse_cnt_reg <= 16'(PULSE_CYC);
      end else if (pulse_on) begin
         pulse_cnt_reg <= pulse_cnt_reg - 16'h0001;
      end
   end

   always_ff @(posedge aclk) begin
      if (rst) begin
         strobe_cnt_reg <= 2'h0;
      end else if (mode == THCS_MODE_RT && rt_reset_cmd_rx) begin
         strobe_cnt_reg <= 2'(THCS_RST_STROBE_CYC);
      end else if (stb_on) begin
         strobe_cnt_reg <= strobe_cnt_reg - 2'h1;
      end
   end

   // User self-test is requested by writing bit 0 of the start register.
   // The enable pin is checked again on a user request, so a low pin blocks both starts.
   always_ff @(posedge aclk) begin
      if (rst) begin
         state_reg    <= THCS_ST_IDLE;
         test_cnt_reg <= 8'h00;
      end else begin
         case (state_reg)
            THCS_ST_IDLE: begin
               state_reg    <= link.selftest_after_reset_en ? THCS_ST_TEST : THCS_ST_RUN;
               test_cnt_reg <= 8'(THCS_SELFTEST_CYC);
            end
            THCS_ST_TEST: begin
               test_cnt_reg <= test_cnt_reg - 8'h01;
               if (test_cnt_reg == 8'h01)
                  state_reg <= THCS_ST_RUN;
            end
            THCS_ST_RUN: begin
               if (wr_start && link.reg_wdata[0] && link.selftest_after_reset_en) begin
                  state_reg    <= THCS_ST_TEST;
                  test_cnt_reg <= 8'(THCS_SELFTEST_CYC);
               end
            end
            default: state_reg <= THCS_ST_IDLE;
         endcase
      end
   end

   // The tag clock is slow and asynchronous, so it is resynchronised before edge detection.
   always_ff @(posedge aclk) begin
      if (rst) begin
         tag_d1_reg <= 1'b0;
         tag_d2_reg <= 1'b0;
         tag_d3_reg <= 1'b0;
      end else begin
         tag_d1_reg <= link.tag_clk;
         tag_d2_reg <= tag_d1_reg;
         tag_d3_reg <= tag_d2_reg;
      end
   end

   always_ff @(posedge aclk) begin
      if (rst)
         time_tag <= 16'h0000;
      else if (ext_tag && tag_rise)
         time_tag <= time_tag + 16'h0001;
   end

   // Registered, so the pin does not glitch while the mode input changes.
   always_ff @(posedge aclk) begin
      if (rst)
         inprog_reg <= 1'b0;
      else if (mode == THCS_MODE_WMON)
         inprog_reg <= monitor_online;
      else
         inprog_reg <= msg_active;
   end

   always_comb begin
      link.message_in_progress_n = ~inprog_reg;
      link.rt_reset_cmd_strobe_n = ~stb_on;
      link.irq_n                 = ~(level_reg || pulse_on);
   end

   // Unmapped terminal offsets read as zero.
   always_comb begin
      case (link.reg_addr)
         THCS_OFF_CFG2: link.reg_rdata = cfg2_reg;
         THCS_OFF_ISR1: link.reg_rdata = isr1_reg;
         THCS_OFF_ISR2: link.reg_rdata = isr2_reg;
         THCS_OFF_IMR:  link.reg_rdata = imr_reg;
         THCS_OFF_TAG:  link.reg_rdata = time_tag;
         default:       link.reg_rdata = 16'h0000;
      endcase
   end

   always_comb begin
      tx_enable_a   = ~link.tx_shutdown_chan_a;
      tx_enable_b   = ~link.tx_shutdown_chan_b;
      selftest_busy = (state_reg == THCS_ST_TEST);
   end
endmodule

// >>> thcs_host.sv
// Host end: AXI4-Lite controller that drives the terminal's control pins.
`timescale 1ns/1ps
module thcs_host
   import thcs_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   thcs_if.host             link,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             irq
);
   import thcs_pkg::*;

   logic [7:0]  awaddr_reg;
   logic [31:0] wdata_reg;
   logic        aw_have_reg;
   logic        w_have_reg;
   logic [4:0]  ctrl_reg;
   logic [1:0]  hirq_reg;
   logic [1:0]  hmask_reg;
   logic        irq_d_reg;
   logic        strobe_d_reg;
   logic        wr_fire;
   logic        rd_fire;
   logic        wr_fwd;
   logic        rd_fwd;
   logic [1:0]  ev;

   assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
   assign s_axi_wready  = !w_have_reg && !s_axi_bvalid;
   // A forwarded write owns the shared terminal address, so a read waits one cycle.
   assign s_axi_arready = !s_axi_rvalid && !wr_fwd;
   assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;
   assign rd_fire = s_axi_arvalid && s_axi_arready;
   // Terminal registers are forwarded below offset 0x20; host-owned ones live from 0x20 up, plus status at 0x18.
   assign wr_fwd  = wr_fire && awaddr_reg < THCS_OFF_CTRL;
   assign rd_fwd  = rd_fire && s_axi_araddr < THCS_OFF_CTRL;
   assign ev      = {~link.irq_n & irq_d_reg, ~link.rt_reset_cmd_strobe_n & strobe_d_reg};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_reg  <= 1'b0;
         w_have_reg   <= 1'b0;
         awaddr_reg   <= 8'h00;
         wdata_reg    <= 32'h00000000;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= THCS_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata;
         end
         if (wr_fire) begin
            aw_have_reg  <= 1'b0;
            w_have_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awaddr_reg > THCS_OFF_HMASK) ? THCS_RESP_SLVERR : THCS_RESP_OKAY;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Control bits: shutdown A, shutdown B, self-test enable, master clear, tag clock.
   always_ff @(posedge aclk) begin
      if (!aresetn)
         ctrl_reg <= 5'h04;
      else if (wr_fire && awaddr_reg == THCS_OFF_CTRL && s_axi_wstrb[0])
         ctrl_reg <= wdata_reg[4:0];
   end

   // A read of the host interrupt register clears it; a new event in that cycle still sets.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hirq_reg     <= 2'h0;
         hmask_reg    <= 2'h0;
         irq_d_reg    <= 1'b1;
         strobe_d_reg <= 1'b1;
      end else begin
         irq_d_reg    <= link.irq_n;
         strobe_d_reg <= link.rt_reset_cmd_strobe_n;
         hirq_reg     <= ((rd_fire && s_axi_araddr == THCS_OFF_HIRQ) ? 2'h0 : hirq_reg) | ev;
         if (wr_fire && awaddr_reg == THCS_OFF_HMASK)
            hmask_reg <= wdata_reg[1:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= THCS_RESP_OKAY;
      end else if (rd_fire) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= (s_axi_araddr > THCS_OFF_HMASK) ? THCS_RESP_SLVERR : THCS_RESP_OKAY;
         case (s_axi_araddr)
            THCS_OFF_STATUS: s_axi_rdata <= {29'h0, link.irq_n, link.rt_reset_cmd_strobe_n,
                                             link.message_in_progress_n};
            THCS_OFF_CTRL:   s_axi_rdata <= {27'h0, ctrl_reg};
            THCS_OFF_HIRQ:   s_axi_rdata <= {30'h0, hirq_reg};
            THCS_OFF_HMASK:  s_axi_rdata <= {30'h0, hmask_reg};
            default:         s_axi_rdata <= rd_fwd ? {16'h0000, link.reg_rdata} : 32'h00000000;
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   always_comb begin
      link.tx_shutdown_chan_a      = ctrl_reg[0];
      link.tx_shutdown_chan_b      = ctrl_reg[1];
      link.selftest_after_reset_en = ctrl_reg[2];
      link.master_clear_n          = aresetn && !ctrl_reg[3];
      link.tag_clk                 = ctrl_reg[4];
      link.reg_wr                  = wr_fwd;
      link.reg_rd                  = rd_fwd;
      link.reg_addr                = wr_fwd ? awaddr_reg : s_axi_araddr;
      link.reg_wdata               = wdata_reg[15:0];
      irq                          = |(hirq_reg & hmask_reg);
   end
endmodule

// >>> thcs_sva.sv
// Concurrent checks on the wires between the host controller and the terminal.
`timescale 1ns/1ps
module thcs_sva
   import thcs_pkg::*;
#(
   parameter int PULSE_CYC = THCS_IRQ_PULSE_CYC
) (
   input logic        aclk,
   input logic        master_clear_n,
   input logic        irq_n,
   input logic        rt_reset_cmd_strobe_n,
   input logic        message_in_progress_n,
   input logic        reg_wr,
   input logic        reg_rd,
   input logic [7:0]  reg_addr,
   input logic [15:0] reg_wdata,
   input logic [15:0] reg_rdata
);
   logic [15:0] cfg2_reg;
   logic [7:0]  low_reg;
   logic        lvl;
   logic        acl;
   logic        sn;
   logic        clr_wr;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!master_clear_n);
   assign lvl    = cfg2_reg[THCS_CFG2_LEVEL_BIT];
   assign acl    = cfg2_reg[THCS_CFG2_AUTOCLR];
   assign sn     = rt_reset_cmd_strobe_n;
   assign clr_wr = reg_wr && (reg_addr == THCS_OFF_START) && reg_wdata[THCS_START_IRQ_RST];
   // Shadow of the configuration word, so the interrupt checks know the selected form.
   always_ff @(posedge aclk) begin
      if (!master_clear_n) begin
         cfg2_reg <= THCS_CFG2_RESET;
      end else if (reg_wr && (reg_addr == THCS_OFF_CFG2)) begin
         cfg2_reg <= reg_wdata;
      end
   end
   // Low samples of the interrupt; it saturates so that a held level cannot wrap round.
   always_ff @(posedge aclk) begin
      if (!master_clear_n || irq_n) begin
         low_reg <= 8'h00;
      end else if (low_reg != 8'hFF) begin
         low_reg <= low_reg + 8'h01;
      end
   end
   AST_STROBE_TWO: assert property ($fell(sn) |-> ##1 !sn ##1 sn)
      else $error("reset strobe not two cycles low");
   AST_STROBE_RISE: assert property ($rose(sn) |-> !$past(sn, 2) && $past(sn, 3))
      else $error("reset strobe rose after a wrong low time");
   AST_PULSE_WIDTH: assert property ($rose(irq_n) && !lvl |-> low_reg == PULSE_CYC)
      else $error("interrupt pulse has wrong width");
   AST_PULSE_MAX: assert property (!lvl |-> low_reg <= PULSE_CYC)
      else $error("interrupt pulse too long");
   AST_LEVEL_HOLD: assert property (lvl && !irq_n && !reg_wr && !$past(reg_wr) &&
      !(acl && (reg_rd || $past(reg_rd))) |=> !irq_n)
      else $error("level interrupt released without a clear");
   AST_LEVEL_CLEAR: assert property (lvl && clr_wr |-> ##[1:2] irq_n)
      else $error("interrupt reset did not release the level");
   AST_CLEAR_RESET: assert property ($rose(master_clear_n) |-> irq_n && sn && message_in_progress_n)
      else $error("outputs not idle after master clear");
   AST_CFG2_READBACK: assert property (reg_rd && !reg_wr && reg_addr == THCS_OFF_CFG2 |-> reg_rdata == cfg2_reg)
      else $error("configuration word reads back wrong");
   COV_STROBE: cover property ($fell(sn));
   COV_PULSE: cover property ($rose(irq_n) && !lvl);
   COV_CLEAR: cover property (lvl && clr_wr);
endmodule

// >>> terminal_host_control_signals_tb.sv
// Self-checking bench for the host controller and terminal joined back to back.
`timescale 1ns/1ps
module terminal_host_control_signals_tb;
   import thcs_pkg::*;
   localparam int PC = 4;
   logic        aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
   logic        awr, wrd, bvl, arr, rvl, irq, txa, txb, busy;
   logic        online = 0, msg = 0, rtcmd = 0;
   logic [1:0]  bresp, rresp, rs;
   logic [7:0]  awa = 0, ara = 0;
   logic [31:0] wdat = 0, rdat, rv;
   logic [15:0] ev1 = 0, ev2 = 0, tag;
   thcs_mode_e  mode = THCS_MODE_BC;
   int          n_fail = 0, checked = 0, cyc = 0;
   thcs_if link_if ();
   thcs_device #(.PULSE_CYC(PC)) thcs_device_inst (.aclk(aclk), .link(link_if), .mode(mode), .monitor_online(online),
      .msg_active(msg), .rt_reset_cmd_rx(rtcmd), .isr1_event(ev1), .isr2_event(ev2), .tx_enable_a(txa),
      .tx_enable_b(txb), .selftest_busy(busy), .time_tag(tag));
   thcs_host thcs_host_inst (.aclk(aclk), .aresetn(aresetn), .link(link_if), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wdat), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvl), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rvl), .s_axi_rready(rry), .irq(irq));
   thcs_sva #(.PULSE_CYC(PC)) thcs_sva_inst (.aclk(aclk), .master_clear_n(link_if.master_clear_n), .irq_n(link_if.irq_n),
      .rt_reset_cmd_strobe_n(link_if.rt_reset_cmd_strobe_n), .message_in_progress_n(link_if.message_in_progress_n),
      .reg_wr(link_if.reg_wr), .reg_rd(link_if.reg_rd), .reg_addr(link_if.reg_addr), .reg_wdata(link_if.reg_wdata),
      .reg_rdata(link_if.reg_rdata));
   always #5 aclk = ~aclk;
   task automatic finish_test;
      $display("counts: checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // The run should take several hundred cycles; far beyond that something hangs.
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         $display("unexpected at %0t: run timed out", $time);
         finish_test;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw, w;
      aw = 0;
      w = 0;
      @(posedge aclk);
      awa <= a;
      wdat <= d;
      awv <= 1;
      wv <= 1;
      bry <= 1;
      while (!(aw && w)) begin
         @(posedge aclk);
         if (!aw && awr === 1'b1) begin
            aw = 1;
            awv <= 0;
         end
         if (!w && wrd === 1'b1) begin
            w = 1;
            wv <= 0;
         end
      end
      do @(posedge aclk); while (bvl !== 1'b1);
      rs = bresp;
      bry <= 0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      ara <= a;
      arv <= 1;
      rry <= 1;
      do @(posedge aclk); while (arr !== 1'b1);
      arv <= 0;
      do @(posedge aclk); while (rvl !== 1'b1);
      rv = rdat;
      rs = rresp;
      rry <= 0;
   endtask
   task automatic cnt(input int n, input int w, output int c);
      c = 0;
      repeat (n) begin
         @(posedge aclk);
         if (w == 0) c += int'(link_if.irq_n === 1'b0);
         else if (w == 1) c += int'(link_if.rt_reset_cmd_strobe_n === 1'b0);
         else c += int'(busy === 1'b1);
      end
   endtask
   task automatic ev(input logic [15:0] a, input logic [15:0] b);
      @(posedge aclk);
      ev1 <= a;
      ev2 <= b;
      @(posedge aclk);
      ev1 <= 0;
      ev2 <= 0;
   endtask
   initial begin
      int c, b;
      logic [15:0] t;
      void'($urandom(47397));
      repeat (12) @(posedge aclk);
      aresetn <= 1;
      cnt(100, 2, c);
      chk(c, THCS_SELFTEST_CYC, "power-up self-test");
      rd(THCS_OFF_STATUS);
      chk(rv, 32'h0000_0007, "idle status");
      rd(THCS_OFF_CTRL);
      chk(rv, 32'h0000_0004, "control reset value");
      $display("end of test reset at %0t", $time);
      wr(THCS_OFF_CTRL, 32'h8);
      wr(THCS_OFF_CTRL, 32'h0);
      cnt(100, 2, c);
      chk(c, 0, "self-test after clear while disabled");
      wr(THCS_OFF_START, 32'h1);
      cnt(100, 2, c);
      chk(c, 0, "user self-test while disabled");
      wr(THCS_OFF_CTRL, 32'h4);
      wr(THCS_OFF_START, 32'h1);
      cnt(100, 2, c);
      chk(c, THCS_SELFTEST_CYC - 1, "user self-test while enabled");
      for (int i = 0; i < 4; i++) begin
         wr(THCS_OFF_CTRL, 32'h4 | i);
         tick(2);
         chk({txb, txa}, {~i[1], ~i[0]}, "transmitter enables");
      end
      wr(THCS_OFF_CTRL, 32'h4);
      $display("end of test self-test and shutdown at %0t", $time);
      repeat (12) begin
         @(posedge aclk);
         mode <= thcs_mode_e'($urandom_range(3));
         msg <= $urandom_range(1);
         online <= $urandom_range(1);
         tick(3);
         chk(link_if.message_in_progress_n, (mode == THCS_MODE_WMON) ? !online : !msg, "in progress");
      end
      for (int i = 0; i < 2; i++) begin
         @(posedge aclk);
         mode <= i ? THCS_MODE_BC : THCS_MODE_RT;
         rtcmd <= 1;
         @(posedge aclk);
         rtcmd <= 0;
         cnt(10, 1, c);
         chk(c, i ? 0 : THCS_RST_STROBE_CYC, "reset strobe length");
      end
      rd(THCS_OFF_HIRQ);
      chk(rv, 32'h1, "strobe event");
      $display("end of test message and strobe at %0t", $time);
      wr(THCS_OFF_IMR, 32'hFFFF);
      wr(THCS_OFF_HMASK, 32'h0);
      b = $urandom_range(15);
      ev(16'h1 << b, 16'h0);
      cnt(30, 0, c);
      chk(c, PC, "pulse width");
      chk(irq, 0, "masked host interrupt");
      rd(THCS_OFF_ISR1);
      chk(rv, 32'h1 << b, "status one");
      rd(THCS_OFF_HIRQ);
      chk(rv, 32'h2, "interrupt fall event");
      wr(THCS_OFF_CFG2, 32'h8);
      wr(THCS_OFF_HMASK, 32'h2);
      ev(16'h0, 16'h1 << b);
      tick(30);
      chk(link_if.irq_n, 0, "level held");
      chk(irq, 1, "host interrupt raised");
      rd(THCS_OFF_ISR2);
      tick(3);
      chk(link_if.irq_n, 0, "read without auto-clear");
      rd(THCS_OFF_HIRQ);
      tick(2);
      chk(irq, 0, "host interrupt cleared by read");
      wr(THCS_OFF_START, 32'h4);
      tick(2);
      chk(link_if.irq_n, 1, "level cleared by reset bit");
      wr(THCS_OFF_CFG2, 32'h18);
      ev(16'h1, 16'h8000);
      tick(3);
      rd(THCS_OFF_ISR1);
      tick(3);
      chk(link_if.irq_n, 0, "one of two status reads");
      rd(THCS_OFF_ISR2);
      tick(3);
      chk(link_if.irq_n, 1, "both status reads");
      ev(16'h0, 16'h4);
      tick(3);
      rd(THCS_OFF_ISR2);
      tick(3);
      chk(link_if.irq_n, 1, "requesting status read");
      $display("end of test interrupts at %0t", $time);
      wr(THCS_OFF_CFG2, 32'h380);
      chk(rs, THCS_RESP_OKAY, "mapped write response");
      rd(THCS_OFF_CFG2);
      chk(rv, 32'h380, "configuration readback");
      t = tag;
      wr(THCS_OFF_CTRL, 32'h14);
      wr(THCS_OFF_CTRL, 32'h4);
      tick(5);
      chk(tag, 16'(t + 16'h1), "external time tag");
      rd(8'h2C);
      chk(rs, THCS_RESP_SLVERR, "unmapped read");
      wr(8'h30, 32'h0);
      chk(rs, THCS_RESP_SLVERR, "unmapped write");
      $display("end of test time tag and decode at %0t", $time);
      finish_test;
   end
endmodule
